//--- design/pllcfg_top.sv
// Purpose: Configuration bank for the synthesizer loop: polarity, pump, dividers.
// Assumes: The serial control port presents byte accesses on reg_* in the clk domain.
// Notes: Read data appears one clock after the read strobe.
`timescale 1ns/1ps
module pllcfg_top
  import pllcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic pfd_negative,
  output logic [2:0] cp_current,
  output logic [1:0] cp_mode,
  output logic [1:0] pll_pd_mode,
  output logic [REF_DIV_W-1:0] ref_divider,
  output logic [SWALLOW_W-1:0] swallow_count,
  output logic [MAIN_W-1:0] main_count,
  output logic [7:0] counter_control,
  output logic pump_up_force,
  output logic pump_down_force,
  output logic pump_hiz,
  output logic pump_pfd_driven,
  output logic [12:0] pump_current_ua,
  output logic loop_pd_async,
  output logic loop_pd_sync,
  output logic update_busy
);

  logic update_pend_reg;
  logic readback_active_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] rdata_next;

  logic wr_loop;
  logic wr_rlo;
  logic wr_rhi;
  logic wr_swl;
  logic wr_mlo;
  logic wr_mhi;
  logic wr_cc;

  logic [7:0] loop_stg;
  logic [7:0] loop_act;
  logic [7:0] rlo_stg;
  logic [7:0] rlo_act;
  logic [5:0] rhi_stg;
  logic [5:0] rhi_act;
  logic [5:0] swl_stg;
  logic [5:0] swl_act;
  logic [7:0] mlo_stg;
  logic [7:0] mlo_act;
  logic [4:0] mhi_stg;
  logic [4:0] mhi_act;
  logic [7:0] cc_stg;
  logic [7:0] cc_act;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  assign wr_loop = reg_wr && addr_hit(reg_addr, OFS_LOOP_CTRL);
  assign wr_rlo = reg_wr && addr_hit(reg_addr, OFS_REF_DIV_LOW);
  assign wr_rhi = reg_wr && addr_hit(reg_addr, OFS_REF_DIV_HIGH);
  assign wr_swl = reg_wr && addr_hit(reg_addr, OFS_SWALLOW);
  assign wr_mlo = reg_wr && addr_hit(reg_addr, OFS_MAIN_LOW);
  assign wr_mhi = reg_wr && addr_hit(reg_addr, OFS_MAIN_HIGH);
  assign wr_cc = reg_wr && addr_hit(reg_addr, OFS_COUNTER_CTRL);

  pllcfg_stage_reg #(.W(8), .RST_VAL(RST_LOOP_CTRL)) u_loop (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_loop),
    .wdata(reg_wdata),
    .update(update_pend_reg),
    .staged(loop_stg),
    .active(loop_act)
  );

  pllcfg_stage_reg #(.W(8), .RST_VAL(RST_REF_DIV_LOW)) u_rlo (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_rlo),
    .wdata(reg_wdata),
    .update(update_pend_reg),
    .staged(rlo_stg),
    .active(rlo_act)
  );

  pllcfg_stage_reg #(.W(6), .RST_VAL(RST_REF_DIV_HIGH)) u_rhi (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_rhi),
    .wdata(reg_wdata[5:0]),
    .update(update_pend_reg),
    .staged(rhi_stg),
    .active(rhi_act)
  );

  pllcfg_stage_reg #(.W(6), .RST_VAL(RST_SWALLOW)) u_swl (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_swl),
    .wdata(reg_wdata[5:0]),
    .update(update_pend_reg),
    .staged(swl_stg),
    .active(swl_act)
  );

  pllcfg_stage_reg #(.W(8), .RST_VAL(RST_MAIN_LOW)) u_mlo (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_mlo),
    .wdata(reg_wdata),
    .update(update_pend_reg),
    .staged(mlo_stg),
    .active(mlo_act)
  );

  pllcfg_stage_reg #(.W(5), .RST_VAL(RST_MAIN_HIGH)) u_mhi (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_mhi),
    .wdata(reg_wdata[4:0]),
    .update(update_pend_reg),
    .staged(mhi_stg),
    .active(mhi_act)
  );

  pllcfg_stage_reg #(.W(8), .RST_VAL(RST_COUNTER_CTRL)) u_cc (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_cc),
    .wdata(reg_wdata),
    .update(update_pend_reg),
    .staged(cc_stg),
    .active(cc_act)
  );

  // The update bit clears one clock after it is set; a new request written in the
  // transfer cycle keeps it set so the second batch of writes is not lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      update_pend_reg <= 1'b0;
    end else if (reg_wr && addr_hit(reg_addr, OFS_UPDATE_ALL) && reg_wdata[0]) begin
      update_pend_reg <= 1'b1;
    end else if (update_pend_reg) begin
      update_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readback_active_reg <= 1'b0;
    end else if (reg_wr && addr_hit(reg_addr, OFS_READBACK_SEL)) begin
      readback_active_reg <= reg_wdata[0];
    end
  end

  // Reserved bits above each field read back as zero.
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      OFS_READBACK_SEL: rdata_next = {7'h00, readback_active_reg};
      OFS_LOOP_CTRL: rdata_next = readback_active_reg ? loop_act : loop_stg;
      OFS_REF_DIV_LOW: rdata_next = readback_active_reg ? rlo_act : rlo_stg;
      OFS_REF_DIV_HIGH: rdata_next = {2'h0, readback_active_reg ? rhi_act : rhi_stg};
      OFS_SWALLOW: rdata_next = {2'h0, readback_active_reg ? swl_act : swl_stg};
      OFS_MAIN_LOW: rdata_next = readback_active_reg ? mlo_act : mlo_stg;
      OFS_MAIN_HIGH: rdata_next = {3'h0, readback_active_reg ? mhi_act : mhi_stg};
      OFS_COUNTER_CTRL: rdata_next = readback_active_reg ? cc_act : cc_stg;
      OFS_UPDATE_ALL: rdata_next = {7'h00, update_pend_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign update_busy = update_pend_reg;

  // Active fields feed the loop straight from the active copies.
  assign pfd_negative = loop_act[POS_POLARITY];
  assign cp_current = loop_act[POS_CP_CUR_LSB +: 3];
  assign cp_mode = loop_act[POS_CP_MODE_LSB +: 2];
  assign pll_pd_mode = loop_act[POS_PD_LSB +: 2];
  assign ref_divider = {rhi_act, rlo_act};
  assign swallow_count = swl_act;
  assign main_count = {mhi_act, mlo_act};
  assign counter_control = cc_act;

  pllcfg_loop_drive u_drive (
    .clk(clk),
    .rst(rst),
    .cp_current(loop_act[POS_CP_CUR_LSB +: 3]),
    .cp_mode(loop_act[POS_CP_MODE_LSB +: 2]),
    .pd_mode(loop_act[POS_PD_LSB +: 2]),
    .pump_up_force(pump_up_force),
    .pump_down_force(pump_down_force),
    .pump_hiz(pump_hiz),
    .pump_pfd_driven(pump_pfd_driven),
    .pump_current_ua(pump_current_ua),
    .loop_pd_async(loop_pd_async),
    .loop_pd_sync(loop_pd_sync)
  );

endmodule : pllcfg_top

//--- design/pllcfg_pkg.sv
// Purpose: Constants for the frequency synthesizer loop configuration bank.
// Assumes: Byte-wide registers reached through the serial control port's register interface.
// Notes: Staged values become active only on the update command.
//
// Behaviour
// - Polarity bit 7 of loop control: 0 positive sense (default), 1 negative.
// - Pump current code scales linearly, 0.6 mA per step, reset code 111.
// - Pump mode: 00 high-Z, 01 source, 10 sink, 11 normal (default).
// - Reference divider is 14 bits; low byte register resets to 0x01.
// - Reference divider upper six bits in bits 5:0 of next register, reset zero.
// - Swallow counter is six bits in low bits of its register, reset zero.
// - Main counter is 13 bits; low byte register resets to 0x03.
// - Main counter upper five bits in bits 4:0 of next register, reset zero.
// - Writes are staged; update-all bit transfers them and clears itself.
// - Readback returns staged values unless readback-select bit returns active ones.
package pllcfg_pkg;

  localparam int ADDR_W = 10;

  localparam logic [ADDR_W-1:0] OFS_READBACK_SEL = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_LOOP_CTRL = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_REF_DIV_LOW = 10'h011;
  localparam logic [ADDR_W-1:0] OFS_REF_DIV_HIGH = 10'h012;
  localparam logic [ADDR_W-1:0] OFS_SWALLOW = 10'h013;
  localparam logic [ADDR_W-1:0] OFS_MAIN_LOW = 10'h014;
  localparam logic [ADDR_W-1:0] OFS_MAIN_HIGH = 10'h015;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_CTRL = 10'h016;
  localparam logic [ADDR_W-1:0] OFS_UPDATE_ALL = 10'h232;

  // Loop control field positions.
  localparam int POS_POLARITY = 7;
  localparam int POS_CP_CUR_LSB = 4;
  localparam int POS_CP_MODE_LSB = 2;
  localparam int POS_PD_LSB = 0;

  localparam int REF_DIV_W = 14;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_W = 13;

  localparam logic [7:0] RST_LOOP_CTRL = 8'h7D;
  localparam logic [7:0] RST_REF_DIV_LOW = 8'h01;
  localparam logic [5:0] RST_REF_DIV_HIGH = 6'h00;
  localparam logic [5:0] RST_SWALLOW = 6'h00;
  localparam logic [7:0] RST_MAIN_LOW = 8'h03;
  localparam logic [4:0] RST_MAIN_HIGH = 5'h00;
  localparam logic [7:0] RST_COUNTER_CTRL = 8'h00;

  // Pump current step in microamps; code 0 gives one step.
  localparam logic [12:0] CP_STEP_UA = 13'h0258;

  typedef enum logic [1:0] {
    PLLCFG_CP_HIZ = 2'b00,
    PLLCFG_CP_SOURCE = 2'b01,
    PLLCFG_CP_SINK = 2'b10,
    PLLCFG_CP_NORMAL = 2'b11
  } pllcfg_cp_mode_t;

  typedef enum logic [1:0] {
    PLLCFG_PD_NORMAL0 = 2'b00,
    PLLCFG_PD_ASYNC = 2'b01,
    PLLCFG_PD_NORMAL1 = 2'b10,
    PLLCFG_PD_SYNC = 2'b11
  } pllcfg_pd_mode_t;

endpackage : pllcfg_pkg

//--- design/pllcfg_stage_reg.sv
// Purpose: One staged field with its buffer copy and its active copy.
// Assumes: Write and update come from the register port logic on the same clock.
// Notes: A write in the update cycle lands in the buffer only.
`timescale 1ns/1ps
module pllcfg_stage_reg
  import pllcfg_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  input wire logic update,
  output logic [W-1:0] staged,
  output logic [W-1:0] active
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      staged <= RST_VAL;
    end else if (wr_en) begin
      staged <= wdata;
    end
  end

  // Active copy takes the buffer value seen at the update edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= RST_VAL;
    end else if (update) begin
      active <= staged;
    end
  end

endmodule : pllcfg_stage_reg

//--- design/pllcfg_loop_drive.sv
// Purpose: Turns the active loop control fields into registered drive controls.
// Assumes: Inputs are active (post-update) values on the same clock.
// Notes: Outputs lag the active fields by one clock.
`timescale 1ns/1ps
module pllcfg_loop_drive
  import pllcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] cp_current,
  input wire logic [1:0] cp_mode,
  input wire logic [1:0] pd_mode,
  output logic pump_up_force,
  output logic pump_down_force,
  output logic pump_hiz,
  output logic pump_pfd_driven,
  output logic [12:0] pump_current_ua,
  output logic loop_pd_async,
  output logic loop_pd_sync
);

  function automatic logic [12:0] current_ua(input logic [2:0] code);
    current_ua = 13'((code + 4'h1) * CP_STEP_UA);
  endfunction : current_ua

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_up_force <= 1'b0;
      pump_down_force <= 1'b0;
      pump_hiz <= 1'b0;
      pump_pfd_driven <= 1'b1;
    end else begin
      pump_up_force <= (cp_mode == PLLCFG_CP_SOURCE);
      pump_down_force <= (cp_mode == PLLCFG_CP_SINK);
      pump_hiz <= (cp_mode == PLLCFG_CP_HIZ);
      pump_pfd_driven <= (cp_mode == PLLCFG_CP_NORMAL);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_current_ua <= current_ua(3'h7);
    end else begin
      pump_current_ua <= current_ua(cp_current);
    end
  end

  // Codes 00 and 10 both mean the loop runs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_pd_async <= 1'b1;
      loop_pd_sync <= 1'b0;
    end else begin
      loop_pd_async <= (pd_mode == PLLCFG_PD_ASYNC);
      loop_pd_sync <= (pd_mode == PLLCFG_PD_SYNC);
    end
  end

endmodule : pllcfg_loop_drive

//--- bench/pllcfg_assertions.sv
// Purpose: Port-level assertions for the loop configuration bank.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound to pllcfg_top below the module.
`timescale 1ns/1ps
module pllcfg_assertions
  import pllcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pfd_negative,
  input wire logic [2:0] cp_current,
  input wire logic [1:0] cp_mode,
  input wire logic [1:0] pll_pd_mode,
  input wire logic [REF_DIV_W-1:0] ref_divider,
  input wire logic [SWALLOW_W-1:0] swallow_count,
  input wire logic [MAIN_W-1:0] main_count,
  input wire logic [7:0] counter_control,
  input wire logic pump_up_force,
  input wire logic pump_down_force,
  input wire logic pump_hiz,
  input wire logic pump_pfd_driven,
  input wire logic [12:0] pump_current_ua,
  input wire logic loop_pd_async,
  input wire logic loop_pd_sync,
  input wire logic update_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic set_upd;
  assign set_upd = reg_wr && (reg_addr == OFS_UPDATE_ALL) && reg_wdata[0];
  AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid)
    else $error("read valid does not follow read strobe");
  AST_RVALID_IDLE: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read strobe");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_UPD_SET: assert property (set_upd |=> update_busy)
    else $error("update bit not set by write");
  AST_UPD_CLEAR: assert property (!set_upd |=> !update_busy)
    else $error("update bit did not clear itself");
  AST_ACTIVE_HOLD: assert property (!update_busy |=> $stable({pfd_negative,
    cp_current, cp_mode, pll_pd_mode, ref_divider, swallow_count, main_count,
    counter_control}))
    else $error("active value changed without update");
  AST_PUMP_DECODE: assert property (1'b1 |=> {pump_hiz, pump_up_force,
    pump_down_force, pump_pfd_driven} == (4'h8 >> $past(cp_mode)))
    else $error("pump mode decode wrong");
  AST_CUR_SCALE: assert property (1'b1 |=> pump_current_ua ==
    ({10'h000, $past(cp_current)} + 13'h0001) * 13'h0258)
    else $error("pump current scale wrong");
  AST_PD_DECODE: assert property (1'b1 |=> {loop_pd_async, loop_pd_sync} ==
    {$past(pll_pd_mode) == 2'h1, $past(pll_pd_mode) == 2'h3})
    else $error("power-down decode wrong");
  cover property (set_upd);
  cover property (cp_mode == PLLCFG_CP_SINK);
  cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule : pllcfg_assertions

bind pllcfg_top pllcfg_assertions chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .pfd_negative(pfd_negative), .cp_current(cp_current),
  .cp_mode(cp_mode), .pll_pd_mode(pll_pd_mode), .ref_divider(ref_divider),
  .swallow_count(swallow_count), .main_count(main_count), .counter_control(counter_control),
  .pump_up_force(pump_up_force), .pump_down_force(pump_down_force), .pump_hiz(pump_hiz),
  .pump_pfd_driven(pump_pfd_driven), .pump_current_ua(pump_current_ua),
  .loop_pd_async(loop_pd_async), .loop_pd_sync(loop_pd_sync), .update_busy(update_busy));

//--- bench/tb_pllcfg_top.sv
// Purpose: Self-checking bench for the loop configuration bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Register rows first, then update, readback and mode sweeps.
`timescale 1ns/1ps
module tb_pllcfg_top
  import pllcfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, counter_control;
  logic reg_rvalid, pfd_negative, pump_up_force, pump_down_force, pump_hiz, pump_pfd_driven;
  logic loop_pd_async, loop_pd_sync, update_busy;
  logic [2:0] cp_current;
  logic [1:0] cp_mode, pll_pd_mode;
  logic [REF_DIV_W-1:0] ref_divider;
  logic [SWALLOW_W-1:0] swallow_count;
  logic [MAIN_W-1:0] main_count;
  logic [12:0] pump_current_ua;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  // Rows: address, reset value, written byte, staged readback. Last row is unmapped.
  logic [ADDR_W-1:0] row_a [8] = '{OFS_LOOP_CTRL, OFS_REF_DIV_LOW, OFS_REF_DIV_HIGH,
    OFS_SWALLOW, OFS_MAIN_LOW, OFS_MAIN_HIGH, OFS_COUNTER_CTRL, 10'h020};
  logic [7:0] row_r [8] = '{8'h7D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  // Negative sense here stands for an external-oscillator setup.
  logic [7:0] row_w [8] = '{8'hA6, 8'h5A, 8'hFF, 8'hFF, 8'hC3, 8'hFF, 8'h81, 8'hFF};
  logic [7:0] row_s [8] = '{8'hA6, 8'h5A, 8'h3F, 8'h3F, 8'hC3, 8'h1F, 8'h81, 8'h00};

  always #5 clk = ~clk;

  pllcfg_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pfd_negative(pfd_negative), .cp_current(cp_current), .cp_mode(cp_mode),
    .pll_pd_mode(pll_pd_mode), .ref_divider(ref_divider), .swallow_count(swallow_count),
    .main_count(main_count), .counter_control(counter_control), .pump_up_force(pump_up_force),
    .pump_down_force(pump_down_force), .pump_hiz(pump_hiz), .pump_pfd_driven(pump_pfd_driven),
    .pump_current_ua(pump_current_ua), .loop_pd_async(loop_pd_async),
    .loop_pd_sync(loop_pd_sync), .update_busy(update_busy));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  // Strobe is dropped and one idle edge passes, so back-to-back calls never reassign it.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    chk("read", {reg_rvalid, reg_rdata}, {1'b1, e});
    step();
  endtask : rd

  task automatic upd;
    reg_addr = OFS_UPDATE_ALL;
    reg_wdata = 8'h01;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    chk("busy_set", update_busy, 1'b1);
    step();
    chk("busy_clr", update_busy, 1'b0);
    step();
  endtask : upd

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("rst_loop", {pfd_negative, cp_current, cp_mode, pll_pd_mode}, 8'h7D);
    chk("rst_div", {ref_divider, swallow_count}, {14'h0001, 6'h00});
    chk("rst_main", main_count, 13'h0003);
    chk("rst_drv", {pump_pfd_driven, loop_pd_async, pump_current_ua}, {2'b11, 13'h12C0});
    for (int i = 0; i < 8; i++) begin
      rd(row_a[i], row_r[i]);
      wr(row_a[i], row_w[i]);
      rd(row_a[i], row_s[i]);
    end
    chk("staged_only", ref_divider, 14'h0001);
    upd();
    chk("act_loop", {pfd_negative, cp_current, cp_mode, pll_pd_mode}, 8'hA6);
    chk("act_div", {ref_divider, swallow_count}, {14'h3F5A, 6'h3F});
    chk("act_main", {main_count, counter_control}, {13'h1FC3, 8'h81});
    chk("act_drv", {pump_up_force, pump_current_ua}, {1'b1, 13'h0708});
    wr(OFS_REF_DIV_LOW, 8'h77);
    wr(OFS_UPDATE_ALL, 8'hFE);
    chk("no_update", ref_divider, 14'h3F5A);
    rd(OFS_REF_DIV_LOW, 8'h77);
    wr(OFS_READBACK_SEL, 8'h01);
    rd(OFS_REF_DIV_LOW, 8'h5A);
    rd(OFS_READBACK_SEL, 8'h01);
    wr(OFS_READBACK_SEL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LOOP_CTRL, {1'b0, i[2:0], i[1:0], i[1:0]});
      upd();
      chk("pump", {pump_hiz, pump_up_force, pump_down_force, pump_pfd_driven}, 4'h8 >> i);
      chk("cur", pump_current_ua, ({10'h000, i[2:0]} + 13'h0001) * 13'h0258);
      chk("pd", {loop_pd_async, loop_pd_sync}, {i[1:0] == 2'h1, i[1:0] == 2'h3});
    end
    // Update request held over two edges: the second request wins over the self-clear.
    reg_addr = OFS_UPDATE_ALL;
    reg_wdata = 8'h01;
    reg_wr = 1'b1;
    step();
    step();
    chk("busy_hold", update_busy, 1'b1);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    chk("busy_read", {reg_rvalid, reg_rdata, update_busy}, {1'b1, 8'h01, 1'b0});
    step();
    rst = 1'b1;
    step();
    rst = 1'b0;
    chk("rerst", {ref_divider, main_count}, {14'h0001, 13'h0003});
    rd(OFS_LOOP_CTRL, 8'h7D);
    tally_and_finish();
  end
endmodule : tb_pllcfg_top
